//--- common/smisel_pkg.sv
// Purpose: shared constants for the stop method and input assignment block
// Assumes: 250 MHz clock, register port with one-cycle read latency
// Notes: settings are 16-bit codes; times in whole seconds
//
// Overview of operation
// - 9999 or 8888: ramp down when start drops
// - 0 to 100: shut off after delay, coast
// - 1000 to 1100: shut off after setting minus 1000
// - start pair meaning follows stop method setting
// - output-active falls when coasting shutoff happens
// - restart during coast begins at starting frequency
// - special stops and jog ignore stop method
// - five terminal settings with documented defaults
// - only listed codes accepted; 60/61 per terminal
// - settings writable only when extended display zero
package smisel_pkg;

    // register indices, byte address is four times the index
    localparam logic [3:0] SMISEL_IDX_IN1 = 4'h0;
    localparam logic [3:0] SMISEL_IDX_IN2 = 4'h1;
    localparam logic [3:0] SMISEL_IDX_IN3 = 4'h2;
    localparam logic [3:0] SMISEL_IDX_IN4 = 4'h3;
    localparam logic [3:0] SMISEL_IDX_IN5 = 4'h4;
    localparam logic [3:0] SMISEL_IDX_STOP = 4'h5;
    localparam logic [3:0] SMISEL_IDX_EXTDISP = 4'h6;
    localparam logic [3:0] SMISEL_IDX_STATUS = 4'h7;
    localparam int SMISEL_ADDR_W = 6;

    // reset values
    localparam logic [15:0] SMISEL_RST_IN1 = 16'h003C;
    localparam logic [15:0] SMISEL_RST_IN2 = 16'h003D;
    localparam logic [15:0] SMISEL_RST_IN3 = 16'h0000;
    localparam logic [15:0] SMISEL_RST_IN4 = 16'h0001;
    localparam logic [15:0] SMISEL_RST_IN5 = 16'h0002;
    localparam logic [15:0] SMISEL_RST_STOP = 16'h270F;
    localparam logic [15:0] SMISEL_RST_EXTDISP = 16'h0000;

    // function codes acted on here
    localparam logic [15:0] SMISEL_FN_LOW = 16'h0000;
    localparam logic [15:0] SMISEL_FN_MID = 16'h0001;
    localparam logic [15:0] SMISEL_FN_HIGH = 16'h0002;
    localparam logic [15:0] SMISEL_FN_FWD = 16'h003C;
    localparam logic [15:0] SMISEL_FN_REV = 16'h003D;
    localparam logic [15:0] SMISEL_FN_NONE = 16'h270F;

    // stop method codes and ranges
    localparam logic [15:0] SMISEL_STOP_RAMP_FR = 16'h270F;
    localparam logic [15:0] SMISEL_STOP_RAMP_SD = 16'h22B8;
    localparam logic [15:0] SMISEL_STOP_DLY_MAX = 16'h0064;
    localparam logic [15:0] SMISEL_STOP_OFS_MIN = 16'h03E8;
    localparam logic [15:0] SMISEL_STOP_OFS_MAX = 16'h044C;

    // timing: delays count whole seconds
    localparam int unsigned SMISEL_CLK_MHZ = 250;
    localparam int unsigned SMISEL_TICK_S = 1;
    localparam int unsigned SMISEL_SEC_CYCLES = SMISEL_CLK_MHZ * 1000000 * SMISEL_TICK_S;

    // controller states
    typedef enum logic [4:0] {
        SMISEL_ST_IDLE  = 5'h01,
        SMISEL_ST_RUN   = 5'h02,
        SMISEL_ST_WAIT  = 5'h04,
        SMISEL_ST_RAMP  = 5'h08,
        SMISEL_ST_COAST = 5'h10
    } smisel_state_t;

endpackage

//--- dv/smisel_ctrl_model.sv
// Purpose: controller driving the terminal contacts
// Assumes: contacts are driven levels
// Notes: contacts move just after an edge
`timescale 1ns/1ps
module smisel_ctrl_model (
    // clock
    input wire logic clock,
    // requested pattern, bit 0 is terminal 1
    input wire logic [4:0] cmd,
    // contacts
    output logic [4:0] pins
);
    // all contacts open at power up
    initial begin
        pins = 5'h00;
        forever begin
            @(posedge clock);
            pins <= cmd;
        end
    end
endmodule

//--- dv/smisel_props.sv
// Purpose: checks on drive commands and read port
// Assumes: one clock, synchronous active-low reset
// Notes: sees top ports only
`timescale 1ns/1ps
module smisel_props
    import smisel_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_r,
    // special stops, jog and ramp done
    input wire logic power_fail_stop,
    input wire logic panel_unit_stop,
    input wire logic comm_err_stop,
    input wire logic jog_mode,
    input wire logic ramp_done,
    // drive commands
    input wire logic output_active_r,
    input wire logic output_shutoff_r,
    input wire logic decel_req_r,
    input wire logic start_freq_restart_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // special stops and jog
    wire logic ovr = power_fail_stop | panel_unit_stop | comm_err_stop | jog_mode;

    // read data only in the read slot
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0)
        else $error("rdata outside slot");
    a_rdata_upper_zero: assert property (reg_rdata_r[31:16] == 16'h0)
        else $error("rdata upper bits");
    a_shutoff_not_active: assert property (output_shutoff_r |-> !output_active_r)
        else $error("active while off");
    a_coast_drops_run: assert property ($rose(output_shutoff_r) && $past(output_active_r) |-> $fell(output_active_r))
        else $error("active stayed at shutoff");
    a_decel_keeps_output: assert property (decel_req_r |-> !output_shutoff_r)
        else $error("shutoff during ramp");
    // ramp reaches shutoff only on ramp done
    a_ramp_no_coast: assert property (decel_req_r && !ramp_done |=> !output_shutoff_r)
        else $error("ramp ended early");
    a_restart_one_cycle: assert property (start_freq_restart_r |=> !start_freq_restart_r)
        else $error("restart pulse long");
    a_restart_after_coast: assert property (start_freq_restart_r |-> $past(output_shutoff_r) && output_active_r)
        else $error("restart without coast");
    a_override_no_restart: assert property ($past(ovr) |-> !start_freq_restart_r)
        else $error("restart under override");
    a_override_ramps: assert property (ovr && output_active_r && !decel_req_r |-> ##1 (decel_req_r || output_shutoff_r))
        else $error("override did not ramp");

    c_restart: cover property (start_freq_restart_r);
    c_ramp: cover property ($rose(decel_req_r));
    c_coast: cover property ($rose(output_shutoff_r) && $past(output_active_r));
endmodule

bind smisel_top smisel_props u_props (
    .clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .power_fail_stop(power_fail_stop), .panel_unit_stop(panel_unit_stop),
    .comm_err_stop(comm_err_stop), .jog_mode(jog_mode), .ramp_done(ramp_done),
    .output_active_r(output_active_r), .output_shutoff_r(output_shutoff_r),
    .decel_req_r(decel_req_r), .start_freq_restart_r(start_freq_restart_r)
);

//--- dv/testbench.sv
// Purpose: directed checks of stop method and terminal settings
// Assumes: a second is SEC cycles
// Notes: outputs sampled 1 ns after the edge
`timescale 1ns/1ps
module testbench;
    import smisel_pkg::*;
    localparam int SEC = 4;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ramp_done = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [4:0] cmd = 5'h00;
    logic [3:0] ovr = 4'h0;
    logic [4:0] pins;
    logic [31:0] reg_rdata_r;
    logic output_active_r, output_shutoff_r, decel_req_r, reverse_dir_r, start_freq_restart_r;
    logic low_speed_select_r, middle_speed_select_r, high_speed_select_r;
    wire logic [31:0] spd = {29'h0, high_speed_select_r, middle_speed_select_r, low_speed_select_r};
    int n_fail = 0;
    int tests_run = 0;
    // reset values in register order, then {index, written, read back}
    logic [15:0] rst_tab [6] = '{16'h003C, 16'h003D, 16'h0000, 16'h0001, 16'h0002, 16'h270F};
    logic [35:0] codes [18] = '{36'h2003C0000, 36'h0003D003C, 36'h1003C003D, 36'h300060001,
        36'h400090002, 36'h400250025, 36'h4270F270F, 36'h400020002, 36'h000430043,
        36'h0003C003C, 36'h300410041, 36'h300010001, 36'h50065270F, 36'h503E7270F,
        36'h5044D270F, 36'h500640064, 36'h522B822B8, 36'h5270F270F};
    // {setting, seconds} in both delay ranges, ends 0, 100 and 1100 included
    logic [31:0] dly [5] = '{32'h00000000, 32'h00020002, 32'h00640064, 32'h03E90001, 32'h044C0064};

    always #2 clock = ~clock;

    smisel_ctrl_model u_ctrl (.clock(clock), .cmd(cmd), .pins(pins));

    smisel_top #(.SEC_CYCLES(SEC)) dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .term1_pin(pins[0]), .term2_pin(pins[1]), .term3_pin(pins[2]),
        .term4_pin(pins[3]), .term5_pin(pins[4]),
        .power_fail_stop(ovr[0]), .panel_unit_stop(ovr[1]), .comm_err_stop(ovr[2]),
        .jog_mode(ovr[3]), .ramp_done(ramp_done),
        .output_active_r(output_active_r), .output_shutoff_r(output_shutoff_r),
        .decel_req_r(decel_req_r), .reverse_dir_r(reverse_dir_r),
        .start_freq_restart_r(start_freq_restart_r), .low_speed_select_r(low_speed_select_r),
        .middle_speed_select_r(middle_speed_select_r), .high_speed_select_r(high_speed_select_r)
    );

    task automatic final_report;
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle strobes; the slave never stalls
    task automatic wr(input logic [3:0] idx, input logic [15:0] v);
        @(posedge clock);
        reg_addr <= {idx, 2'b00};
        reg_wdata <= {16'h0000, v};
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_r, {16'h0000, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // pins move one edge later, logic sees them three after
    task automatic drive(input logic [4:0] v, input int n);
        @(posedge clock);
        cmd <= v;
        cyc(n);
    endtask

    // {active, shutoff, decel, reverse} under mask
    task automatic outs(input logic [3:0] e, input logic [3:0] m);
        chk({28'h0, {output_active_r, output_shutoff_r, decel_req_r, reverse_dir_r} & m}, {28'h0, e & m});
    endtask

    task automatic ramp_pulse;
        @(posedge clock);
        ramp_done <= 1'b1;
        @(posedge clock);
        ramp_done <= 1'b0;
        cyc(2);
    endtask

    // release to shutoff: sync, delay, timer
    task automatic wait_shut(input int d);
        int n;
        n = 0;
        while (output_shutoff_r !== 1'b1 && n < d * SEC + 20) begin
            cyc(1);
            n++;
        end
        chk({31'h0, n >= d * SEC + 6 && n <= d * SEC + 8}, 32'h1);
    endtask

    task automatic see_restart;
        int hits;
        hits = 0;
        repeat (8) begin
            cyc(1);
            if (start_freq_restart_r === 1'b1) hits++;
        end
        chk(hits, 32'h1);
    endtask

    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rd({4'(i), 2'b00}, rst_tab[i]);
        rd(6'h18, 16'h0000);
        foreach (codes[i]) begin
            wr(codes[i][35:32], codes[i][31:16]);
            rd({codes[i][35:32], 2'b00}, codes[i][15:0]);
        end
        // settings locked while extended display is non-zero
        wr(4'h6, 16'h0001);
        wr(4'h5, 16'h0000);
        wr(4'h2, 16'h0005);
        rd(6'h14, 16'h270F);
        rd(6'h08, 16'h0000);
        rd(6'h18, 16'h0001);
        wr(4'h6, 16'h0000);
        rd(6'h20, 16'h0000);
        rd(6'h15, 16'h0000);
        // ramp stop, forward/reverse pair
        drive(5'h01, 6); outs(4'b1000, 4'hF);
        drive(5'h00, 6); outs(4'b0010, 4'b0110);
        cyc(20); outs(4'b0010, 4'b0110);
        ramp_pulse; outs(4'b0100, 4'b1110);
        drive(5'h02, 6); outs(4'b1001, 4'hF);
        drive(5'h03, 6); outs(4'b0010, 4'b0110);
        drive(5'h00, 2);
        ramp_pulse;
        // start plus direction meaning
        wr(4'h5, 16'h22B8);
        drive(5'h03, 6); outs(4'b1001, 4'hF);
        drive(5'h02, 6); outs(4'b0010, 4'b0110);
        drive(5'h00, 2);
        ramp_pulse;
        // coast stop, then restart
        foreach (dly[i]) begin
            wr(4'h5, dly[i][31:16]);
            drive(5'h01, 6); outs(4'b1000, 4'b1110);
            drive(5'h00, 0);
            wait_shut(int'(dly[i][15:0]));
            outs(4'b0100, 4'b1110);
            drive(5'h01, 0);
            see_restart;
            outs(4'b1000, 4'b1110);
        end
        // reassert restarts the delay
        wr(4'h5, 16'h0002);
        drive(5'h00, 8);
        drive(5'h01, 6);
        drive(5'h00, 0);
        wait_shut(2);
        // special stops override coasting
        for (int k = 0; k < 4; k++) begin
            drive(5'h01, 6);
            @(posedge clock);
            ovr <= 4'(1 << k);
            cyc(3); outs(4'b0010, 4'b0110);
            drive(5'h00, 20); outs(4'b0010, 4'b0110);
            ramp_pulse;
            @(posedge clock);
            ovr <= 4'h0;
        end
        // speed terminals, then terminal 3 moved to high speed
        for (int j = 2; j < 5; j++) begin
            drive(5'(1 << j), 5);
            chk(spd, 32'(1 << (j - 2)));
        end
        drive(5'h00, 5);
        wr(4'h2, 16'h0002);
        drive(5'h04, 5);
        chk(spd, 32'h4);
        final_report;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        final_report;
    end
endmodule

//--- logic/smisel_coast_timer.sv
// Purpose: counts whole seconds from start release to output shutoff
// Assumes: clear has priority over counting
// Notes: the second divider restarts on clear so every delay is exact
`timescale 1ns/1ps
module smisel_coast_timer
    import smisel_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SMISEL_SEC_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic clear,
    input wire logic count_en,
    input wire logic [6:0] delay_s,
    // result
    output logic expired_r
);

    logic [27:0] div_r;
    logic [6:0] secs_r;

    // one-second enable divider, zeroed by clear
    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            div_r <= 28'h0000000;
        end else if (count_en) begin
            div_r <= (div_r == 28'(SEC_CYCLES - 1)) ? 28'h0000000 : div_r + 28'h0000001;
        end
    end

    // elapsed seconds, clear restarts from zero
    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            secs_r <= 7'h00;
        end else if (count_en && div_r == 28'(SEC_CYCLES - 1) && secs_r != 7'h7F) begin
            secs_r <= secs_r + 7'h01;
        end
    end

    // expiry flag
    always_ff @(posedge clock) begin
        if (!rst_n || clear) begin
            expired_r <= 1'b0;
        end else if (count_en && secs_r >= delay_s) begin
            expired_r <= 1'b1;
        end
    end

endmodule

//--- logic/smisel_code_check.sv
// Purpose: decides whether a value may be stored in a setting register
// Assumes: purely combinational, same clock domain as the caller
// Notes: index selects which register the value is meant for
`timescale 1ns/1ps
module smisel_code_check
    import smisel_pkg::*;
(
    // request
    input wire logic [3:0] idx,
    input wire logic [15:0] value,
    // verdict
    output logic ok
);

    // terminal code table; 60 and 61 belong to one terminal each
    function automatic logic term_ok(input logic [3:0] i, input logic [15:0] v);
        logic r;
        r = (v <= 16'h0005) || (v == 16'h0007) || (v == 16'h0008) ||
            (v == 16'h000A) || (v == 16'h000C) || (v == 16'h000E) ||
            (v == 16'h0010) || (v == 16'h0012) || (v == 16'h0018) ||
            (v == 16'h0019) || (v == 16'h0025) || (v == 16'h003E) ||
            (v >= 16'h0041 && v <= 16'h0043) || (v == SMISEL_FN_NONE);
        if (v == SMISEL_FN_FWD) begin
            r = (i == SMISEL_IDX_IN1);
        end
        if (v == SMISEL_FN_REV) begin
            r = (i == SMISEL_IDX_IN2);
        end
        return r;
    endfunction

    // stop method accepts delay ranges and the two ramp codes
    always_comb begin
        ok = 1'b1;
        if (idx == SMISEL_IDX_STOP) begin
            ok = (value <= SMISEL_STOP_DLY_MAX) ||
                 (value >= SMISEL_STOP_OFS_MIN && value <= SMISEL_STOP_OFS_MAX) ||
                 (value == SMISEL_STOP_RAMP_FR) || (value == SMISEL_STOP_RAMP_SD);
        end else if (idx <= SMISEL_IDX_IN5) begin
            ok = term_ok(idx, value);
        end
    end

endmodule

//--- logic/smisel_top.sv
// Purpose: stop method selection, start input meaning and terminal functions
// Assumes: terminals are asynchronous pins; stop requests come from same-clock logic
// Notes: registers sit on a plain strobe port, read data one cycle after the strobe
`timescale 1ns/1ps
module smisel_top
    import smisel_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SMISEL_SEC_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire logic [SMISEL_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_r,
    // input terminal pins
    input wire logic term1_pin,
    input wire logic term2_pin,
    input wire logic term3_pin,
    input wire logic term4_pin,
    input wire logic term5_pin,
    // stop overrides and ramp done from the rest of the drive
    input wire logic power_fail_stop,
    input wire logic panel_unit_stop,
    input wire logic comm_err_stop,
    input wire logic jog_mode,
    input wire logic ramp_done,
    // drive commands
    output logic output_active_r,
    output logic output_shutoff_r,
    output logic decel_req_r,
    output logic reverse_dir_r,
    output logic start_freq_restart_r,
    output logic low_speed_select_r,
    output logic middle_speed_select_r,
    output logic high_speed_select_r
);

    logic [15:0] in_fn_r [5];
    logic [15:0] stop_sel_r;
    logic [15:0] ext_disp_r;
    logic [4:0] pin_meta_r;
    logic [4:0] pin_sync_r;
    logic [3:0] wr_idx;
    logic wr_hit;
    logic wr_ok;
    logic code_ok;
    logic [3:0] rd_idx;
    logic rd_hit;
    logic [31:0] rd_nxt;
    logic fwd_in;
    logic rev_in;
    logic low_in;
    logic mid_in;
    logic high_in;
    logic mode_ramp;
    logic mode_sd;
    logic [6:0] coast_s;
    logic override;
    logic start_cmd;
    logic dir_cmd;
    logic timer_clear;
    logic timer_en;
    logic timer_expired;
    smisel_state_t state_r;
    smisel_state_t state_nxt;

    // word address decode: byte address is four times the index
    function automatic logic [3:0] word_idx(input logic [SMISEL_ADDR_W-1:0] a);
        return a[SMISEL_ADDR_W-1:2];
    endfunction

    function automatic logic addr_hit(input logic [SMISEL_ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a[SMISEL_ADDR_W-1:2] <= SMISEL_IDX_STATUS);
    endfunction

    // true when any terminal holding the given code is active
    function automatic logic fn_active(input logic [15:0] code,
                                       input logic [15:0] f0, input logic [15:0] f1,
                                       input logic [15:0] f2, input logic [15:0] f3,
                                       input logic [15:0] f4, input logic [4:0] p);
        return (p[0] && f0 == code) || (p[1] && f1 == code) || (p[2] && f2 == code) ||
               (p[3] && f3 == code) || (p[4] && f4 == code);
    endfunction

    assign wr_idx = word_idx(reg_addr);
    assign wr_hit = reg_wr && addr_hit(reg_addr);
    assign rd_idx = word_idx(reg_addr);
    assign rd_hit = addr_hit(reg_addr);

    // value check for setting writes
    smisel_code_check u_check (
        .idx(wr_idx),
        .value(reg_wdata[15:0]),
        .ok(code_ok)
    );

    // settings are locked unless extended display is zero; bad codes are dropped
    assign wr_ok = wr_hit && code_ok && (ext_disp_r == 16'h0000);

    // terminal function registers with their defaults
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            in_fn_r[0] <= SMISEL_RST_IN1;
            in_fn_r[1] <= SMISEL_RST_IN2;
            in_fn_r[2] <= SMISEL_RST_IN3;
            in_fn_r[3] <= SMISEL_RST_IN4;
            in_fn_r[4] <= SMISEL_RST_IN5;
        end else if (wr_ok && wr_idx <= SMISEL_IDX_IN5) begin
            in_fn_r[wr_idx[2:0]] <= reg_wdata[15:0];
        end
    end

    // stop method register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stop_sel_r <= SMISEL_RST_STOP;
        end else if (wr_ok && wr_idx == SMISEL_IDX_STOP) begin
            stop_sel_r <= reg_wdata[15:0];
        end
    end

    // extended display selection, always writable since it is the lock itself
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ext_disp_r <= SMISEL_RST_EXTDISP;
        end else if (wr_hit && wr_idx == SMISEL_IDX_EXTDISP) begin
            ext_disp_r <= reg_wdata[15:0];
        end
    end

    // read mux; unmapped and misaligned addresses read zero
    always_comb begin
        rd_nxt = 32'h00000000;
        if (rd_hit) begin
            unique case (rd_idx)
                SMISEL_IDX_IN1: rd_nxt = {16'h0000, in_fn_r[0]};
                SMISEL_IDX_IN2: rd_nxt = {16'h0000, in_fn_r[1]};
                SMISEL_IDX_IN3: rd_nxt = {16'h0000, in_fn_r[2]};
                SMISEL_IDX_IN4: rd_nxt = {16'h0000, in_fn_r[3]};
                SMISEL_IDX_IN5: rd_nxt = {16'h0000, in_fn_r[4]};
                SMISEL_IDX_STOP: rd_nxt = {16'h0000, stop_sel_r};
                SMISEL_IDX_EXTDISP: rd_nxt = {16'h0000, ext_disp_r};
                SMISEL_IDX_STATUS: rd_nxt = {19'h00000, pin_sync_r, state_r, output_active_r,
                                             output_shutoff_r, reverse_dir_r};
                default: rd_nxt = 32'h00000000;
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata_r <= 32'h00000000;
        end else begin
            reg_rdata_r <= reg_rd ? rd_nxt : 32'h00000000;
        end
    end

    // two-stage synchroniser for the terminal pins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pin_meta_r <= 5'h00;
            pin_sync_r <= 5'h00;
        end else begin
            pin_meta_r <= {term5_pin, term4_pin, term3_pin, term2_pin, term1_pin};
            pin_sync_r <= pin_meta_r;
        end
    end

    // map terminals to signals through their function codes
    assign fwd_in = fn_active(SMISEL_FN_FWD, in_fn_r[0], in_fn_r[1], in_fn_r[2],
                              in_fn_r[3], in_fn_r[4], pin_sync_r);
    assign rev_in = fn_active(SMISEL_FN_REV, in_fn_r[0], in_fn_r[1], in_fn_r[2],
                              in_fn_r[3], in_fn_r[4], pin_sync_r);
    assign low_in = fn_active(SMISEL_FN_LOW, in_fn_r[0], in_fn_r[1], in_fn_r[2],
                              in_fn_r[3], in_fn_r[4], pin_sync_r);
    assign mid_in = fn_active(SMISEL_FN_MID, in_fn_r[0], in_fn_r[1], in_fn_r[2],
                              in_fn_r[3], in_fn_r[4], pin_sync_r);
    assign high_in = fn_active(SMISEL_FN_HIGH, in_fn_r[0], in_fn_r[1], in_fn_r[2],
                               in_fn_r[3], in_fn_r[4], pin_sync_r);

    // stop method decode
    assign mode_ramp = (stop_sel_r == SMISEL_STOP_RAMP_FR) ||
                       (stop_sel_r == SMISEL_STOP_RAMP_SD);
    assign mode_sd = (stop_sel_r == SMISEL_STOP_RAMP_SD) ||
                     (stop_sel_r >= SMISEL_STOP_OFS_MIN && stop_sel_r <= SMISEL_STOP_OFS_MAX);

    // coast delay in seconds: plain value or offset by 1000
    always_comb begin
        coast_s = 7'h00;
        if (stop_sel_r <= SMISEL_STOP_DLY_MAX) begin
            coast_s = stop_sel_r[6:0];
        end else if (stop_sel_r >= SMISEL_STOP_OFS_MIN && stop_sel_r <= SMISEL_STOP_OFS_MAX) begin
            coast_s = 7'(stop_sel_r - SMISEL_STOP_OFS_MIN);
        end
    end

    // start pair meaning: fwd/rev start, or start plus direction
    always_comb begin
        if (mode_sd) begin
            start_cmd = fwd_in;
            dir_cmd = rev_in;
        end else begin
            start_cmd = fwd_in ^ rev_in; // both on counts as a stop, a common safe choice
            dir_cmd = rev_in;
        end
    end

    // special stops and jog bypass the stop method and always ramp
    assign override = power_fail_stop || panel_unit_stop || comm_err_stop || jog_mode;

    // coast timer runs only while waiting, cleared on every other state
    assign timer_clear = (state_r != SMISEL_ST_WAIT) || start_cmd;
    assign timer_en = (state_r == SMISEL_ST_WAIT);

    smisel_coast_timer #(
        .SEC_CYCLES(SEC_CYCLES)
    ) u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .clear(timer_clear),
        .count_en(timer_en),
        .delay_s(coast_s),
        .expired_r(timer_expired)
    );

    // stop sequence state machine
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SMISEL_ST_IDLE: begin
                if (start_cmd && !override) begin
                    state_nxt = SMISEL_ST_RUN;
                end
            end
            SMISEL_ST_RUN: begin
                if (override || (!start_cmd && mode_ramp)) begin
                    state_nxt = SMISEL_ST_RAMP;
                end else if (!start_cmd) begin
                    state_nxt = SMISEL_ST_WAIT;
                end
            end
            SMISEL_ST_WAIT: begin
                if (override) begin
                    state_nxt = SMISEL_ST_RAMP;
                end else if (start_cmd) begin
                    state_nxt = SMISEL_ST_RUN;
                end else if (timer_expired) begin
                    state_nxt = SMISEL_ST_COAST;
                end
            end
            SMISEL_ST_RAMP: begin
                if (start_cmd && !override) begin
                    state_nxt = SMISEL_ST_RUN;
                end else if (ramp_done) begin
                    state_nxt = SMISEL_ST_IDLE;
                end
            end
            SMISEL_ST_COAST: begin
                if (start_cmd && !override) begin
                    state_nxt = SMISEL_ST_RUN;
                end
            end
            default: state_nxt = SMISEL_ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= SMISEL_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // output-active falls in the same edge the output is shut off
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            output_active_r <= 1'b0;
            output_shutoff_r <= 1'b1;
        end else begin
            output_active_r <= (state_nxt == SMISEL_ST_RUN) || (state_nxt == SMISEL_ST_WAIT) ||
                               (state_nxt == SMISEL_ST_RAMP);
            output_shutoff_r <= (state_nxt == SMISEL_ST_IDLE) || (state_nxt == SMISEL_ST_COAST);
        end
    end

    // deceleration request while ramping down
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            decel_req_r <= 1'b0;
        end else begin
            decel_req_r <= (state_nxt == SMISEL_ST_RAMP);
        end
    end

    // direction is latched only while a start is asserted so it holds during the stop
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reverse_dir_r <= 1'b0;
        end else if (start_cmd) begin
            reverse_dir_r <= dir_cmd;
        end
    end

    // one-cycle pulse: restart from the starting frequency setting after coasting
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            start_freq_restart_r <= 1'b0;
        end else begin
            start_freq_restart_r <= (state_r == SMISEL_ST_COAST) && (state_nxt == SMISEL_ST_RUN);
        end
    end

    // speed selections follow their assigned terminals
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_speed_select_r <= 1'b0;
            middle_speed_select_r <= 1'b0;
            high_speed_select_r <= 1'b0;
        end else begin
            low_speed_select_r <= low_in;
            middle_speed_select_r <= mid_in;
            high_speed_select_r <= high_in;
        end
    end

endmodule
